//--- rtl/vsc_consts.vh
`ifndef VSC_CONSTS_VH
`define VSC_CONSTS_VH

// ---------------------------------------------------------------------------
// Register indices
// ---------------------------------------------------------------------------
`define VSC_REG_LINE_LENGTH_AND_MASKING    4'h0
`define VSC_REG_VERTICAL_OUTPUT_POLARITIES 4'h1
`define VSC_REG_PATTERN_GROUP_SELECTION    4'h2
`define VSC_REG_GROUP_B_START_LENGTH       4'h3
`define VSC_REG_GROUP_A_START_LENGTH       4'h4
`define VSC_REG_GROUP_B_REPEAT_COUNTS      4'h5
`define VSC_REG_GROUP_A_REPEAT_COUNTS      4'h6
`define VSC_REG_GROUP_A_LATE_REPEATS       4'h7
`define VSC_REG_FIRST_FREEZE_RESUME        4'h8
`define VSC_REG_SECOND_FREEZE_RESUME       4'h9
`define VSC_REG_SEQUENCE_CONTROL           4'ha
`define VSC_REG_SEQUENCE_STATUS            4'hb
`define VSC_NUM_REGS                       12

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define VSC_CLAMP_POL_BIT     0
`define VSC_PREBLANK_POL_BIT  1
`define VSC_MASK_LSB          3
`define VSC_MASK_MSB          4
`define VSC_HORIZONTAL_BLANKING_ALT_LSB      5
`define VSC_HORIZONTAL_BLANKING_ALT_MSB      7
`define VSC_LO13_MSB          12
`define VSC_HI13_LSB          13
`define VSC_HI13_MSB          25
`define VSC_CNT12_MSB         11
`define VSC_HI12_MSB          24
`define VSC_COMBINE_BIT       13
`define VSC_PATSEL_B_LSB      14
`define VSC_PATSEL_B_MSB      18
`define VSC_PATSEL_A_LSB      19
`define VSC_PATSEL_A_MSB      23
`define VSC_ALT_MODE_LSB      24
`define VSC_ALT_MODE_MSB      25
`define VSC_ENABLE_BIT        0

// ---------------------------------------------------------------------------
// Reset values and widths
// ---------------------------------------------------------------------------
`define VSC_REG_RESET         26'h0000000
`define VSC_DATA_W            26
`define VSC_ADDR_W            4

`endif

//--- rtl/vsc_regfile.v
`timescale 1ns/10ps
`include "vsc_consts.vh"

module vsc_regfile #(
  parameter DATA_W = `VSC_DATA_W,
  parameter ADDR_W = `VSC_ADDR_W,
  parameter NREGS  = `VSC_NUM_REGS
) (
  input  wire                      mclk_i,
  input  wire                      rst_n_i,
  input  wire [ADDR_W-1:0]         addr_i,
  input  wire [DATA_W-1:0]         wdata_i,
  input  wire                      wr_i,
  input  wire                      rd_i,
  input  wire [DATA_W-1:0]         status_i,
  output wire [NREGS*DATA_W-1:0]   regs_o,
  output reg  [DATA_W-1:0]         rdata_o
);

  reg [DATA_W-1:0] mem_r [0:NREGS-1];
  integer          i;
  genvar           g;

  // -------------------------------------------------------------------------
  // Storage; status word is read-only
  // -------------------------------------------------------------------------
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < NREGS; i = i + 1) begin
        mem_r[i] <= `VSC_REG_RESET;
      end
    end else if (wr_i && addr_i < `VSC_REG_SEQUENCE_STATUS) begin
      mem_r[addr_i] <= wdata_i;
    end
  end

  generate
    for (g = 0; g < NREGS; g = g + 1) begin : g_flat
      assign regs_o[g*DATA_W +: DATA_W] = mem_r[g];
    end
  endgenerate

  // -------------------------------------------------------------------------
  // Registered read; unmapped reads zero
  // -------------------------------------------------------------------------
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= {DATA_W{1'b0}};
    end else if (rd_i) begin
      if (addr_i == `VSC_REG_SEQUENCE_STATUS) begin
        rdata_o <= status_i;
      end else if (addr_i < `VSC_REG_SEQUENCE_STATUS) begin
        rdata_o <= mem_r[addr_i];
      end else begin
        rdata_o <= {DATA_W{1'b0}};
      end
    end else begin
      rdata_o <= {DATA_W{1'b0}};
    end
  end

endmodule // vsc_regfile

//--- rtl/vsc_vertical_sequence.v
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`include "vsc_consts.vh"

// Summary of operation
// - The two-bit mask field enables none, the first, the second or both freeze/resume pairs.
// - Alternation mode 0 uses the first-line group A count on every line; 1, 2, 3 cycle over 2, 3, 4 lines.
// - Group select 0 runs group A and 1 runs group B.
// - With the combine bit set both groups run together to build one pattern.
// - The 13-bit line length sets the pixel period of every line.
// - Two five-bit fields pick the group A and group B patterns and are presented on outputs.
// - Group B pattern starts at its start pixel and lasts its length.
// - Group A pattern starts at its start pixel and lasts its length.
// - Group B repeats by the odd-line count on odd lines and the even-line count on even lines.
// - Group A repeats by the first-line count on first lines and the second-line count on second lines.
// - Between an enabled freeze point and its resume point all vertical outputs hold, then the pattern goes on.
// - Third-line and fourth-line group A counts serve 3-line and 4-line alternation.
module vsc_vertical_sequence (
  input  wire        mclk_i,
  input  wire        rst_n_i,
  input  wire [3:0]  addr_i,
  input  wire [25:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output wire [25:0] rdata_o,
  output reg  [12:0] vertical_output_o,
  output reg         black_clamp_pulse_o,
  output reg         preblank_pulse_o,
  output reg         horizontal_sync_o,
  output reg  [4:0]  group_a_pattern_select_o,
  output reg  [4:0]  group_b_pattern_select_o,
  output reg  [2:0]  hblank_alternation_select_o
);

  wire [`VSC_NUM_REGS*26-1:0] regs;
  wire [25:0]                 status;

  // -------------------------------------------------------------------------
  // Register fields
  // -------------------------------------------------------------------------
  wire [25:0] r_len   = regs[`VSC_REG_LINE_LENGTH_AND_MASKING*26 +: 26];
  wire [25:0] r_pol   = regs[`VSC_REG_VERTICAL_OUTPUT_POLARITIES*26 +: 26];
  wire [25:0] r_grp   = regs[`VSC_REG_PATTERN_GROUP_SELECTION*26 +: 26];
  wire [25:0] r_b     = regs[`VSC_REG_GROUP_B_START_LENGTH*26 +: 26];
  wire [25:0] r_a     = regs[`VSC_REG_GROUP_A_START_LENGTH*26 +: 26];
  wire [25:0] r_brep  = regs[`VSC_REG_GROUP_B_REPEAT_COUNTS*26 +: 26];
  wire [25:0] r_arep  = regs[`VSC_REG_GROUP_A_REPEAT_COUNTS*26 +: 26];
  wire [25:0] r_arep2 = regs[`VSC_REG_GROUP_A_LATE_REPEATS*26 +: 26];
  wire [25:0] r_frz1  = regs[`VSC_REG_FIRST_FREEZE_RESUME*26 +: 26];
  wire [25:0] r_frz2  = regs[`VSC_REG_SECOND_FREEZE_RESUME*26 +: 26];
  wire [25:0] r_ctl   = regs[`VSC_REG_SEQUENCE_CONTROL*26 +: 26];

  // -------------------------------------------------------------------------
  // Field decode
  // -------------------------------------------------------------------------
  wire [12:0] line_length  = r_len[`VSC_HI13_MSB:`VSC_HI13_LSB];
  wire [1:0]  output_mask_select = r_len[`VSC_MASK_MSB:`VSC_MASK_LSB];
  wire        clamp_start_polarity    = r_len[`VSC_CLAMP_POL_BIT];
  wire        preblank_start_polarity = r_len[`VSC_PREBLANK_POL_BIT];
  wire [12:0] start_pol    = r_pol[`VSC_LO13_MSB:0];
  wire [12:0] second_pol   = r_pol[`VSC_HI13_MSB:`VSC_HI13_LSB];
  wire        group_select = |r_grp[`VSC_LO13_MSB:0];
  wire        combine      = r_grp[`VSC_COMBINE_BIT];
  wire [1:0]  group_a_alternation_mode = r_grp[`VSC_ALT_MODE_MSB:`VSC_ALT_MODE_LSB];
  wire        seq_enable   = r_ctl[`VSC_ENABLE_BIT];

  // -------------------------------------------------------------------------
  // Engine state
  // -------------------------------------------------------------------------
  reg  [12:0] pix_r;
  reg  [11:0] line_r;
  reg  [1:0]  alt_r;
  reg         run_r;
  reg  [12:0] pos_r   [0:1];
  reg  [11:0] cnt_r   [0:1];
  reg  [1:0]  act_r;
  reg  [1:0]  done_r;
  reg  [12:0] vout_nxt;

  wire [12:0] st   [0:1];
  wire [12:0] ln   [0:1];
  reg  [11:0] rp   [0:1];
  wire [1:0]  en;
  wire [1:0]  go;
  wire [1:0]  live;
  wire [12:0] cpos [0:1];
  wire [11:0] ccnt [0:1];
  wire        wrap;
  wire        frz;
  integer     g;

  function in_span;
    input [12:0] p;
    input [25:0] fr;
    begin
      in_span = (p >= fr[`VSC_LO13_MSB:0]) && (p < fr[`VSC_HI13_MSB:`VSC_HI13_LSB]);
    end
  endfunction

  function starts;
    input        enable;
    input        busy;
    input        finished;
    input [12:0] pix;
    input [12:0] start;
    input [12:0] len;
    input [11:0] reps;
    begin
      starts = enable && !busy && !finished && (pix == start) && (len != 13'h0000) && (reps != 12'h000);
    end
  endfunction

  assign st[0] = r_a[`VSC_LO13_MSB:0];
  assign ln[0] = r_a[`VSC_HI13_MSB:`VSC_HI13_LSB];
  assign st[1] = r_b[`VSC_LO13_MSB:0];
  assign ln[1] = r_b[`VSC_HI13_MSB:`VSC_HI13_LSB];
  assign en[0] = combine | ~group_select;
  assign en[1] = combine | group_select;

  // -------------------------------------------------------------------------
  // Pattern start, the start pixel is the first pattern pixel
  // -------------------------------------------------------------------------
  assign go[0]   = starts(en[0], act_r[0], done_r[0], pix_r, st[0], ln[0], rp[0]);
  assign go[1]   = starts(en[1], act_r[1], done_r[1], pix_r, st[1], ln[1], rp[1]);
  assign live    = act_r | go;
  assign cpos[0] = act_r[0] ? pos_r[0] : 13'h0000;
  assign cpos[1] = act_r[1] ? pos_r[1] : 13'h0000;
  assign ccnt[0] = act_r[0] ? cnt_r[0] : 12'h000;
  assign ccnt[1] = act_r[1] ? cnt_r[1] : 12'h000;

  // -------------------------------------------------------------------------
  // Line end and freeze windows
  // -------------------------------------------------------------------------
  assign wrap = (line_length == 13'h0000) || (pix_r >= line_length - 13'h0001);

  assign frz = (output_mask_select[0] && in_span(pix_r, r_frz1)) ||
               (output_mask_select[1] && in_span(pix_r, r_frz2));

  // -------------------------------------------------------------------------
  // Repeat counts per line kind
  // -------------------------------------------------------------------------
  always @* begin
    case (alt_r)
      2'h0: rp[0] = r_arep[`VSC_CNT12_MSB:0];
      2'h1: rp[0] = r_arep[`VSC_HI12_MSB:`VSC_HI13_LSB];
      2'h2: rp[0] = r_arep2[`VSC_CNT12_MSB:0];
      2'h3: rp[0] = r_arep2[`VSC_HI12_MSB:`VSC_HI13_LSB];
      default: rp[0] = r_arep[`VSC_CNT12_MSB:0];
    endcase
    rp[1] = line_r[0] ? r_brep[`VSC_HI12_MSB:`VSC_HI13_LSB]
                      : r_brep[`VSC_CNT12_MSB:0];
  end

  // -------------------------------------------------------------------------
  // Pixel, line and alternation counters
  // -------------------------------------------------------------------------
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pix_r  <= 13'h0000;
      line_r <= 12'h000;
      alt_r  <= 2'h0;
      run_r  <= 1'b0;
    end else if (!seq_enable) begin
      pix_r  <= 13'h0000;
      line_r <= 12'h000;
      alt_r  <= 2'h0;
      run_r  <= 1'b0;
    end else begin
      run_r <= 1'b1;
      if (run_r) begin
        if (wrap) begin
          pix_r  <= 13'h0000;
          line_r <= line_r + 12'h001;
          if (alt_r >= group_a_alternation_mode) begin
            alt_r <= 2'h0;
          end else begin
            alt_r <= alt_r + 2'h1;
          end
        end else begin
          pix_r <= pix_r + 13'h0001;
        end
      end
    end
  end

  // -------------------------------------------------------------------------
  // Pattern engines, index 0 group A, index 1 group B
  // -------------------------------------------------------------------------
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_r  <= 2'b00;
      done_r <= 2'b00;
      for (g = 0; g < 2; g = g + 1) begin
        pos_r[g] <= 13'h0000;
        cnt_r[g] <= 12'h000;
      end
    end else if (!run_r || wrap) begin
      act_r  <= 2'b00;
      done_r <= 2'b00;
      for (g = 0; g < 2; g = g + 1) begin
        pos_r[g] <= 13'h0000;
        cnt_r[g] <= 12'h000;
      end
    end else begin
      for (g = 0; g < 2; g = g + 1) begin
        if (live[g] && !frz) begin
          if (cpos[g] >= ln[g] - 13'h0001) begin
            pos_r[g] <= 13'h0000;
            cnt_r[g] <= ccnt[g] + 12'h001;
            if (ccnt[g] >= rp[g] - 12'h001) begin
              act_r[g]  <= 1'b0;
              done_r[g] <= 1'b1;
            end else begin
              act_r[g]  <= 1'b1;
            end
          end else begin
            act_r[g] <= 1'b1;
            pos_r[g] <= cpos[g] + 13'h0001;
            cnt_r[g] <= ccnt[g];
          end
        end else if (go[g]) begin
          act_r[g] <= 1'b1;
          pos_r[g] <= 13'h0000;
          cnt_r[g] <= 12'h000;
        end
      end
    end
  end

  // -------------------------------------------------------------------------
  // Second phase on even repetitions of any running group
  // -------------------------------------------------------------------------
  always @* begin
    if (!run_r) begin
      vout_nxt = start_pol;
    end else if (frz) begin
      vout_nxt = vertical_output_o;
    end else if ((live[0] && !ccnt[0][0]) || (live[1] && !ccnt[1][0])) begin
      vout_nxt = second_pol;
    end else begin
      vout_nxt = start_pol;
    end
  end

  // -------------------------------------------------------------------------
  // Output registers
  // -------------------------------------------------------------------------
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vertical_output_o           <= 13'h0000;
      black_clamp_pulse_o         <= 1'b0;
      preblank_pulse_o            <= 1'b0;
      horizontal_sync_o           <= 1'b0;
      group_a_pattern_select_o    <= 5'h00;
      group_b_pattern_select_o    <= 5'h00;
      hblank_alternation_select_o <= 3'h0;
    end else begin
      vertical_output_o           <= vout_nxt;
      black_clamp_pulse_o         <= clamp_start_polarity;
      preblank_pulse_o            <= preblank_start_polarity;
      horizontal_sync_o           <= run_r && (pix_r == 13'h0000);
      group_a_pattern_select_o    <= r_grp[`VSC_PATSEL_A_MSB:`VSC_PATSEL_A_LSB];
      group_b_pattern_select_o    <= r_grp[`VSC_PATSEL_B_MSB:`VSC_PATSEL_B_LSB];
      hblank_alternation_select_o <= r_len[`VSC_HORIZONTAL_BLANKING_ALT_MSB:`VSC_HORIZONTAL_BLANKING_ALT_LSB];
    end
  end

  // -------------------------------------------------------------------------
  // Status word and register storage
  // -------------------------------------------------------------------------
  assign status = {run_r, act_r, alt_r, pix_r[8:0], line_r};

  vsc_regfile #(
    .DATA_W (26),
    .ADDR_W (4),
    .NREGS  (`VSC_NUM_REGS)
  ) u_regs (
    .mclk_i   (mclk_i),
    .rst_n_i  (rst_n_i),
    .addr_i   (addr_i),
    .wdata_i  (wdata_i),
    .wr_i     (wr_i),
    .rd_i     (rd_i),
    .status_i (status),
    .regs_o   (regs),
    .rdata_o  (rdata_o)
  );

endmodule // vsc_vertical_sequence

//--- dv/vsc_vertical_sequence_monitor.sv
`timescale 1ns/10ps
module vsc_vertical_sequence_monitor (
  input wire        mclk_i,
  input wire        rst_n_i,
  input wire [3:0]  addr_i,
  input wire [25:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [25:0] rdata_o,
  input wire [12:0] vertical_output_o,
  input wire        black_clamp_pulse_o,
  input wire        preblank_pulse_o,
  input wire        horizontal_sync_o,
  input wire [4:0]  group_a_pattern_select_o,
  input wire [4:0]  group_b_pattern_select_o,
  input wire [2:0]  hblank_alternation_select_o
);
  // ----------------------------------------
  // Shadow of writes, line gap, quiet time
  // ----------------------------------------
  reg  [25:0] shadow_r [0:10];
  reg  [12:0] gap_r;
  reg         gap_ok_r;
  reg  [3:0]  quiet_r;
  integer     i;
  wire [25:0] pick_w   = shadow_r[addr_i];
  wire [12:0] len_w    = shadow_r[0][25:13];
  wire [12:0] period_w = (len_w < 13'h0002) ? 13'h0001 : len_w;
  wire        run_w    = shadow_r[10][0];
  wire        frz_w    = (shadow_r[0][3] && gap_r >= shadow_r[8][12:0] && gap_r < shadow_r[8][25:13]) ||
                         (shadow_r[0][4] && gap_r >= shadow_r[9][12:0] && gap_r < shadow_r[9][25:13]);

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < 11; i = i + 1)
        shadow_r[i] <= 26'h0;
      gap_r    <= 13'h0;
      gap_ok_r <= 1'b0;
      quiet_r  <= 4'h0;
    end else begin
      if (wr_i && addr_i <= 4'ha)
        shadow_r[addr_i] <= wdata_i;
      gap_r    <= horizontal_sync_o ? 13'h0001 : gap_r + 13'h0001;
      gap_ok_r <= wr_i ? 1'b0 : (horizontal_sync_o | gap_ok_r);
      quiet_r  <= wr_i ? 4'h0 : ((quiet_r == 4'hf) ? quiet_r : quiet_r + 4'h1);
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rd_map; rd_i && addr_i <= 4'ha; endsequence
  sequence s_wr0; wr_i && addr_i == 4'h0; endsequence
  sequence s_wr2; wr_i && addr_i == 4'h2; endsequence

  a_read_value: assert property (s_rd_map |=> rdata_o == $past(pick_w)) else $error("read data wrong");
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 26'h0) else $error("read data not zero");
  a_unmapped_zero: assert property (rd_i && addr_i >= 4'hc |=> rdata_o == 26'h0) else $error("unmapped read");
  a_clamp_follow: assert property (s_wr0 |-> ##2 {preblank_pulse_o, black_clamp_pulse_o} ==
    $past(wdata_i[1:0], 2)) else $error("clamp or blank level wrong");
  a_hblank_follow: assert property (s_wr0 |-> ##2 hblank_alternation_select_o == $past(wdata_i[7:5], 2))
    else $error("hblank select wrong");
  a_patsel_follow: assert property (s_wr2 |-> ##2 {group_a_pattern_select_o, group_b_pattern_select_o} ==
    $past(wdata_i[23:14], 2)) else $error("pattern select wrong");
  a_idle_polarity: assert property (!run_w && quiet_r >= 4'h3 |-> vertical_output_o == shadow_r[1][12:0])
    else $error("idle outputs wrong");
  a_sync_period: assert property (horizontal_sync_o && gap_ok_r |-> gap_r == period_w)
    else $error("line period wrong");
  a_freeze_hold: assert property (run_w && gap_ok_r && quiet_r >= 4'h3 && frz_w && !horizontal_sync_o |->
    $stable(vertical_output_o)) else $error("outputs moved while frozen");
  a_sync_stops: assert property (!run_w && quiet_r >= 4'h3 |-> !horizontal_sync_o) else $error("sync while idle");
endmodule // vsc_vertical_sequence_monitor

bind vsc_vertical_sequence vsc_vertical_sequence_monitor u_mon (.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .vertical_output_o, .black_clamp_pulse_o, .preblank_pulse_o, .horizontal_sync_o,
  .group_a_pattern_select_o, .group_b_pattern_select_o, .hblank_alternation_select_o);

//--- dv/vsc_vertical_sequence_tb_top.sv
`timescale 1ns/10ps
module vsc_vertical_sequence_tb_top;
  localparam [12:0] P = 13'h0aaa;
  localparam [12:0] Q = 13'h1555;
  reg         mclk_i  = 1'b0;
  reg         rst_n_i = 1'b0;
  reg  [3:0]  addr_i  = 4'h0;
  reg  [25:0] wdata_i = 26'h0;
  reg         wr_i    = 1'b0;
  reg         rd_i    = 1'b0;
  reg  [25:0] d;
  wire [25:0] rdata_o;
  wire [12:0] vout;
  wire        clamp, pblank, hsync;
  wire [4:0]  psel_a, psel_b;
  wire [2:0]  halt;
  integer     failures = 0;
  integer     compares = 0;
  integer     i;

  always #5 mclk_i = ~mclk_i;

  vsc_vertical_sequence dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .vertical_output_o(vout), .black_clamp_pulse_o(clamp),
    .preblank_pulse_o(pblank), .horizontal_sync_o(hsync), .group_a_pattern_select_o(psel_a),
    .group_b_pattern_select_o(psel_b), .hblank_alternation_select_o(halt));

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task check(input [25:0] seen, input [25:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wr(input [3:0] a, input [25:0] v);
    @(posedge mclk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= v;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task rd(input [3:0] a, output [25:0] v);
    @(posedge mclk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask

  // Count second-phase cycles over one 20-pixel line
  task line_count(input [7:0] exp);
    integer k, c;
    c = 0;
    k = 0;
    #1;
    while (hsync !== 1'b1 && k < 100) begin
      @(posedge mclk_i); #1; k = k + 1;
    end
    for (k = 0; k < 20; k = k + 1) begin
      @(posedge mclk_i); #1;
      if (vout === Q) c = c + 1;
    end
    check({25'h0, hsync}, 26'h1);
    check(c[25:0], {18'h0, exp});
  endtask

  // Restart the sequence with new settings, then check four lines
  task run(input [25:0] r0, input [25:0] r2, input [25:0] r6, input [31:0] e);
    wr(4'ha, 26'h0);
    wr(4'h0, r0);
    wr(4'h2, r2);
    wr(4'h6, r6);
    wr(4'ha, 26'h1);
    for (i = 3; i >= 0; i = i - 1)
      line_count(e[i*8 +: 8]);
  endtask

  task final_report;
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #500000;
    failures = failures + 1;
    final_report;
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (i = 0; i < 11; i = i + 1) begin
      rd(i[3:0], d); check(d, 26'h0);
    end
    for (i = 0; i < 11; i = i + 1)
      wr(i[3:0], (26'h2b45a5a + i) & 26'h3ffe0ff);
    for (i = 0; i < 11; i = i + 1) begin
      rd(i[3:0], d); check(d, (26'h2b45a5a + i) & 26'h3ffe0ff);
    end
    wr(4'hc, 26'h3ffffff);
    rd(4'hc, d); check(d, 26'h0);
    wr(4'hb, 26'h3ffffff);
    rd(4'hb, d); check(d, 26'h0);
    wr(4'ha, 26'h0);
    wr(4'h1, {Q, P});
    wr(4'h0, (26'd20 << 13) | 26'h0a3);
    wr(4'h2, (26'h13 << 19) | (26'h0c << 14));
    repeat (3) @(posedge mclk_i);
    #1;
    check({23'h0, halt, pblank, clamp}, 26'h17);
    check({16'h0, psel_a, psel_b}, 26'h26c);
    check({13'h0, vout}, {13'h0, P});
    wr(4'h3, {13'd2, 13'd10});
    wr(4'h4, {13'd3, 13'd2});
    wr(4'h5, {1'b0, 12'd1, 1'b0, 12'd3});
    wr(4'h7, {1'b0, 12'd2, 1'b0, 12'd5});
    wr(4'h8, {13'd5, 13'd3});
    wr(4'h9, {13'd6, 13'd3});
    run(26'd20 << 13, 26'h0, {13'd1, 13'd3}, 32'h06060606);
    run(26'd20 << 13, 26'h1 << 24, {13'd1, 13'd3}, 32'h06030603);
    run(26'd20 << 13, 26'h2 << 24, {13'd1, 13'd3}, 32'h06030906);
    run(26'd20 << 13, 26'h3 << 24, {13'd1, 13'd3}, 32'h06030903);
    run(26'd20 << 13, 26'h1, {13'd1, 13'd3}, 32'h04020402);
    run(26'd20 << 13, 26'h1 << 13, {13'd1, 13'd1}, 32'h07050705);
    run(26'd20 << 13, 26'h0, {13'd1, 13'd1}, 32'h03030303);
    run((26'd20 << 13) | (26'h1 << 3), 26'h0, {13'd1, 13'd1}, 32'h05050505);
    run((26'd20 << 13) | (26'h2 << 3), 26'h0, {13'd1, 13'd1}, 32'h06060606);
    run((26'd20 << 13) | (26'h3 << 3), 26'h0, {13'd1, 13'd1}, 32'h06060606);
    final_report;
  end
endmodule // vsc_vertical_sequence_tb_top
